/* pkg/bss_consts.vh */
// Timing constants and encodings for the baler stroke sequencer.
`ifndef BSS_CONSTS_VH
`define BSS_CONSTS_VH
`define BSS_CLK_HZ 10000000
`define BSS_PRESS_QUAL_MS 1000
`define BSS_UNL_BLANK_MS 2000
`define BSS_PRESS_QUAL_CYC ((`BSS_CLK_HZ / 1000) * `BSS_PRESS_QUAL_MS)
`define BSS_UNL_BLANK_CYC ((`BSS_CLK_HZ / 1000) * `BSS_UNL_BLANK_MS)
`define BSS_DOOR_MISMATCH_CYC 1000
`define BSS_CNT_W 32
`define BSS_MSG_NONE 2'h0
`define BSS_MSG_HOT 2'h1
`define BSS_MSG_FULL 2'h2
`define BSS_MSG_DOOR 2'h3
`endif

/* design/bss_sync.v */
// Two-stage synchroniser bank for asynchronous switch inputs.
`timescale 1ns/10ps
module bss_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Data
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   // The first stage feeds only the second stage.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         stage1 <= INIT;
         stage2 <= INIT;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
      end
   end

   assign sync_out = stage2;
endmodule // bss_sync

/* design/bss_qual.v */
// Latched qualification timer: input must hold for COUNT cycles.
`timescale 1ns/10ps
module bss_qual #(
   parameter CNT_W = 32,
   parameter [CNT_W-1:0] COUNT = 32'd10000000
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Control
   input wire level,
   input wire clear,
   output reg qualified
);
   reg [CNT_W-1:0] count;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= {CNT_W{1'b0}};
         qualified <= 1'b0;
      end else begin
         if (!level) begin
            count <= {CNT_W{1'b0}};
         end else if (count < COUNT) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // A new qualification wins over a clear in the same cycle.
         if (level && count == COUNT - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            qualified <= 1'b1;
         end else if (clear) begin
            qualified <= 1'b0;
         end
      end
   end
endmodule // bss_qual

/* design/bss_stroke_seq.v */
// Baler stroke sequencer: stroke control, full bale, door and heat lockout.
// How it works
// - The pressure input is active low, high meaning the switch is open.
// - Pressure counts only after one second of unbroken low, then latches.
// - Stroke end and cylinder position come from pressure and drive way.
// - The full-bale limit input is active low at full extension.
// - Pressure before the full-bale limit during compaction flags full.
// - While active, not full and beam blocked, cycles keep starting.
// - Two door contacts that disagree lock out all baler operation.
// - The door lamp is lit while the door is open or lockout holds.
// - Over-temperature halts everything and shows the hot message.
// - The un-loader input is ignored for two seconds of every stroke.
// - With an un-loader, pressure on a down stroke before it flags full.
// - Un-loader closure stops drive at top and bottom of travel.
// - A stroke ends on un-loader closure or qualified pressure.
`timescale 1ns/10ps
`include "bss_consts.vh"
module bss_stroke_seq #(
   parameter CNT_W = `BSS_CNT_W,
   parameter [CNT_W-1:0] PRESS_QUAL_CYC = `BSS_PRESS_QUAL_CYC,
   parameter [CNT_W-1:0] UNL_BLANK_CYC = `BSS_UNL_BLANK_CYC,
   parameter [CNT_W-1:0] DOOR_MISMATCH_CYC = `BSS_DOOR_MISMATCH_CYC
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Operator controls
   input wire enable,
   input wire start,
   input wire unloader_fitted,
   input wire full_clear,
   // Switch inputs, all asynchronous
   input wire pressure_n,
   input wire limit_n,
   input wire door_a_n,
   input wire door_b_n,
   input wire hot,
   input wire beam_blocked,
   // Drive and indication
   output reg drive_up,
   output reg drive_down,
   output reg extended,
   output reg retracted,
   output reg bale_full,
   output reg lockout,
   output reg door_led,
   output reg [1:0] message,
   output reg stroke_done
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_DOWN = 4'h2;
   localparam [3:0] ST_UP = 4'h4;
   localparam [3:0] ST_HALT = 4'h8;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisation.

   wire [5:0] sync_in;
   wire press_low;
   wire limit_low;
   wire door_a_shut;
   wire door_b_shut;
   wire hot_s;
   wire beam_s;

   bss_sync #(.WIDTH(6), .INIT(6'h0F)) u_sync (
      .clk(clk),
      .reset(reset),
      .async_in({beam_blocked, hot, door_b_n, door_a_n, limit_n,
         pressure_n}),
      .sync_out(sync_in)
   );

   assign press_low = ~sync_in[0];
   assign limit_low = ~sync_in[1];
   // Door contacts pull low when the door is shut.
   assign door_a_shut = ~sync_in[2];
   assign door_b_shut = ~sync_in[3];
   assign hot_s = sync_in[4];
   assign beam_s = sync_in[5];

   ////////////////////////////////////////////////////////////////////////
   // Pressure qualification and stroke blanking.

   reg [3:0] state;
   reg [3:0] next_state;
   reg [CNT_W-1:0] blank_cnt;
   reg [CNT_W-1:0] door_cnt;
   reg press_seen;
   wire press_q;
   wire in_stroke;
   wire blank_done;
   wire limit_seen;
   wire stroke_end;
   wire door_mismatch;
   wire door_open;
   wire stop_all;

   bss_qual #(.CNT_W(CNT_W), .COUNT(PRESS_QUAL_CYC)) u_qual (
      .clk(clk),
      .reset(reset),
      .level(press_low),
      .clear(stroke_end | ~in_stroke),
      .qualified(press_q)
   );

   assign in_stroke = (state == ST_DOWN) || (state == ST_UP);
   assign blank_done = (blank_cnt >= UNL_BLANK_CYC);
   // The un-loader shares the limit input when fitted.
   assign limit_seen = unloader_fitted && blank_done && limit_low;
   assign stroke_end = in_stroke && (press_q || limit_seen);

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         blank_cnt <= {CNT_W{1'b0}};
         press_seen <= 1'b0;
      end else begin
         press_seen <= press_q;
         if (!in_stroke || stroke_end) begin
            blank_cnt <= {CNT_W{1'b0}};
         end else if (!blank_done) begin
            blank_cnt <= blank_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Door and thermal safety.

   // A brief skew between contacts halts the drives; a lasting one locks out.
   assign door_mismatch = door_a_shut ^ door_b_shut;
   assign door_open = ~door_a_shut & ~door_b_shut;

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         door_cnt <= {CNT_W{1'b0}};
         lockout <= 1'b0;
         door_led <= 1'b1;
      end else begin
         if (!door_mismatch) begin
            door_cnt <= {CNT_W{1'b0}};
         end else if (door_cnt < DOOR_MISMATCH_CYC) begin
            door_cnt <= door_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // The lockout holds until both contacts open together again.
         if (door_mismatch && door_cnt >= DOOR_MISMATCH_CYC) begin
            lockout <= 1'b1;
         end else if (door_open) begin
            lockout <= 1'b0;
         end
         door_led <= door_open | door_mismatch | lockout;
      end
   end

   assign stop_all = lockout | door_mismatch | door_open | hot_s;

   ////////////////////////////////////////////////////////////////////////
   // Stroke sequencer.

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (stop_all) begin
               next_state = ST_HALT;
            end else if (enable && (start || (beam_s && !bale_full))) begin
               next_state = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (stop_all) begin
               next_state = ST_HALT;
            end else if (stroke_end) begin
               next_state = ST_UP;
            end
         end
         ST_UP: begin
            if (stop_all) begin
               next_state = ST_HALT;
            end else if (stroke_end) begin
               next_state = ST_IDLE;
            end
         end
         ST_HALT: begin
            if (!stop_all) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_HALT;
         end
      endcase
   end

   // Drives follow the next state so that the contactor and the state move
   // on the same edge; a stop therefore drops both drives at once.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_HALT;
         drive_up <= 1'b0;
         drive_down <= 1'b0;
         stroke_done <= 1'b0;
      end else begin
         state <= next_state;
         drive_down <= (next_state == ST_DOWN);
         drive_up <= (next_state == ST_UP);
         stroke_done <= stroke_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Cylinder position, full bale and display.

   // Message priority: heat outranks the door, the door outranks full.
   function [1:0] msg_code;
      input is_hot;
      input is_door;
      input is_full;
      begin
         if (is_hot) begin
            msg_code = `BSS_MSG_HOT;
         end else if (is_door) begin
            msg_code = `BSS_MSG_DOOR;
         end else if (is_full) begin
            msg_code = `BSS_MSG_FULL;
         end else begin
            msg_code = `BSS_MSG_NONE;
         end
      end
   endfunction

   // There is no position sensor, so both flags stay low mid-stroke and
   // after a halted stroke until the next stroke end is seen.
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         extended <= 1'b0;
         retracted <= 1'b0;
      end else begin
         if (stroke_end && state == ST_DOWN) begin
            extended <= 1'b1;
            retracted <= 1'b0;
         end else if (stroke_end && state == ST_UP) begin
            extended <= 1'b0;
            retracted <= 1'b1;
         end else if (in_stroke) begin
            extended <= 1'b0;
            retracted <= 1'b0;
         end
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         bale_full <= 1'b0;
      end else begin
         // Full wins over an operator clear in the same cycle.
         if (state == ST_DOWN && press_q && !press_seen &&
            (unloader_fitted ? !limit_seen : !limit_low)) begin
            bale_full <= 1'b1;
         end else if (full_clear) begin
            bale_full <= 1'b0;
         end
      end
   end

   always @(posedge clk or posedge reset) begin
      if (reset) begin
         message <= `BSS_MSG_NONE;
      end else begin
         message <= msg_code(hot_s, lockout | door_mismatch | door_open,
            bale_full);
      end
   end
endmodule // bss_stroke_seq

/* verif/bss_props.sv */
// Concurrent checks for the baler stroke sequencer.
`timescale 1ns/10ps
`include "bss_consts.vh"
module bss_props #(
   parameter CNT_W = 32,
   parameter [CNT_W-1:0] PRESS_QUAL_CYC = 20,
   parameter [CNT_W-1:0] UNL_BLANK_CYC = 40
) (
   // Clock, reset and inputs
   input wire clk,
   input wire reset,
   input wire unloader_fitted,
   input wire pressure_n,
   input wire door_a_n,
   input wire door_b_n,
   input wire hot,
   // Outputs
   input wire drive_up,
   input wire drive_down,
   input wire extended,
   input wire bale_full,
   input wire lockout,
   input wire door_led,
   input wire [1:0] message,
   input wire stroke_done
);
   reg [15:0] low_cnt;
   reg [15:0] run_cnt;
   wire drv = drive_up | drive_down;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         low_cnt <= 16'h0000;
         run_cnt <= 16'h0000;
      end else begin
         low_cnt <= pressure_n ? 16'h0000 : low_cnt + 16'h0001;
         run_cnt <= drv && !stroke_done ? run_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   chk_press_qual: assert property (
      stroke_done && !unloader_fitted |-> low_cnt >= PRESS_QUAL_CYC)
      else $error("early pressure end");
   // The margin allows for the synchroniser and the switch letting go.
   chk_press_ends: assert property (
      low_cnt > PRESS_QUAL_CYC + 6 |-> !drv) else $error("stroke overran");
   chk_unl_blank: assert property (
      stroke_done |-> run_cnt >= UNL_BLANK_CYC || low_cnt >= PRESS_QUAL_CYC)
      else $error("blanking ignored");
   chk_hot_halt: assert property (
      hot [*4] |=> !drv && message == `BSS_MSG_HOT) else $error("hot run");
   chk_door_stop: assert property (
      (door_a_n ^ door_b_n) [*4] |=> !drv) else $error("door drive");
   chk_lock_led: assert property (
      lockout [*2] |-> door_led) else $error("lamp dark");
   chk_full_down: assert property (
      $rose(bale_full) |-> $past(drive_down)) else $error("full off down");
   chk_up_extend: assert property (
      $rose(drive_up) |-> extended && stroke_done) else $error("no extend");
   cov_full: cover property ($rose(bale_full));
   cov_lock: cover property ($rose(lockout));
   cov_hot: cover property (hot && drv);
endmodule // bss_props
bind bss_stroke_seq bss_props #(.CNT_W(CNT_W),
   .PRESS_QUAL_CYC(PRESS_QUAL_CYC), .UNL_BLANK_CYC(UNL_BLANK_CYC))
   i_bss_props (.*);

/* verif/bss_cyl_model.sv */
// Cylinder with its pressure switch and limit switch.
`timescale 1ns/10ps
module bss_cyl_model (
   // Drive from the sequencer
   input wire clk,
   input wire drive_up,
   input wire drive_down,
   // Scenario controls
   input wire [7:0] travel,
   input wire jam,
   // Switch contacts, pulled up when open
   output wire pressure_n,
   output wire limit_n
);
   reg [7:0] pos = 8'h00;
   reg was_up = 1'b0;
   always @(posedge clk) begin
      was_up <= drive_up;
      if (!(drive_up || drive_down) || drive_up != was_up)
         pos <= 8'h00;
      else if (pos != 8'hFF)
         pos <= pos + 8'h01;
   end
   // A jammed bale loads the ram half way, before the limit can close.
   assign pressure_n = !((drive_up || drive_down) && (pos > travel + 8'h02 ||
      (jam && drive_down && pos > travel / 2)));
   assign limit_n = !(pos < 8'h03 ||
      (pos > travel && !(jam && drive_down)));
endmodule // bss_cyl_model

/* verif/tb_top.sv */
// Self-checking testbench for the baler stroke sequencer.
`timescale 1ns/10ps
`include "bss_consts.vh"
`define BSS_CHK(n, e, a) begin tests_run = tests_run + 1; \
   if ((a) !== (e)) begin fails = fails + 1; \
   $display("ERROR %s exp %h got %h", n, e, a); end end
module tb_top;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg enable = 1'b0;
   reg start = 1'b0;
   reg unloader_fitted = 1'b0;
   reg full_clear = 1'b0;
   reg door_a_n = 1'b1;
   reg door_b_n = 1'b1;
   reg hot = 1'b0;
   reg beam_blocked = 1'b0;
   reg jam = 1'b0;
   reg [7:0] travel = 8'h40;
   reg [31:0] lfsr = 32'h31B5D1CA;
   integer fails = 0;
   integer tests_run = 0;
   integer i;
   wire pressure_n, limit_n, drive_up, drive_down, extended, retracted;
   wire bale_full, lockout, door_led, stroke_done;
   wire [1:0] message;
   always #50 clk = ~clk;
   bss_stroke_seq #(.PRESS_QUAL_CYC(32'h14), .UNL_BLANK_CYC(32'h28),
      .DOOR_MISMATCH_CYC(32'h5)) i_bss_stroke_seq (.*);
   bss_cyl_model i_bss_cyl_model (.*);
   function [31:0] next_rand(input [31:0] s);
      next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Hot outranks the door, and the door outranks a full bale.
   function [1:0] exp_msg(input h, input d, input f);
      exp_msg = h ? `BSS_MSG_HOT : d ? `BSS_MSG_DOOR :
         f ? `BSS_MSG_FULL : `BSS_MSG_NONE;
   endfunction
   task end_sim;
      begin
         $display("tests_run=%0d fails=%0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task wait_done;
      integer n;
      begin
         n = 0;
         do begin
            @(negedge clk);
            n = n + 1;
         end while (stroke_done !== 1'b1 && n < 400);
         if (stroke_done !== 1'b1) begin
            $display("ERROR stroke_done exp 1 got %b", stroke_done);
            fails = fails + 1;
            end_sim;
         end
      end
   endtask
   task run(input fit, input jm);
      begin
         unloader_fitted = fit;
         jam = jm;
         lfsr = next_rand(lfsr);
         travel = 8'h2D + {2'b00, lfsr[5:0]};
         start = 1'b1;
         @(negedge clk);
         start = 1'b0;
         wait_done;
         `BSS_CHK("up", 1'b1, drive_up)
         `BSS_CHK("full", jm, bale_full)
         wait_done;
         `BSS_CHK("ret", 1'b1, retracted & ~drive_up)
         `BSS_CHK("msg", exp_msg(1'b0, 1'b0, jm), message)
         full_clear = 1'b1;
         @(negedge clk);
         full_clear = 1'b0;
         @(negedge clk);
         `BSS_CHK("clr", 1'b0, bale_full)
         $display("TEST run fit=%0d jam=%0d done", fit, jm);
      end
   endtask
   initial begin
      repeat (3) @(negedge clk);
      reset = 1'b0;
      `BSS_CHK("led", 1'b1, door_led)
      door_a_n = 1'b0;
      door_b_n = 1'b0;
      enable = 1'b1;
      repeat (6) @(negedge clk);
      for (i = 0; i < 8; i = i + 1)
         run(i[0], i[1]);
      jam = 1'b0;
      travel = 8'h64;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (45) @(negedge clk);
      hot = 1'b1;
      repeat (5) @(negedge clk);
      `BSS_CHK("hot", 1'b0, drive_up | drive_down)
      `BSS_CHK("hmsg", `BSS_MSG_HOT, message)
      hot = 1'b0;
      door_b_n = 1'b1;
      repeat (12) @(negedge clk);
      `BSS_CHK("lock", 1'b1, lockout & door_led)
      door_a_n = 1'b1;
      repeat (4) @(negedge clk);
      `BSS_CHK("unlock", 1'b0, lockout)
      door_a_n = 1'b0;
      door_b_n = 1'b0;
      beam_blocked = 1'b1;
      wait_done;
      wait_done;
      repeat (4) @(negedge clk);
      `BSS_CHK("again", 1'b1, drive_down)
      beam_blocked = 1'b0;
      wait_done;
      wait_done;
      repeat (5) @(negedge clk);
      `BSS_CHK("idle", 1'b0, drive_down)
      $display("TEST safety and beam done");
      end_sim;
   end
endmodule // tb_top
